// file: hdl/clk_source_cfg.sv
/*
 * register slice selecting the reference source, running the crystal
 * oscillator and holding per-output idle codes, plus the output drivers.
 * assumes the serial bus front end presents byte accesses on req and
 * that per-output enable bits arrive on outen.
 */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - on-demand: oscillator runs only in crystal mode
// - policy zero keeps oscillator running except in bypass
// - codes 00/01 route differential pair one/two
// - 10 crystal, 11 bypass with buffer off
// - source field bits 1:0, upper bits zero
// - idle codes: both low, drive low, high-Z
// - idle code used only while output disabled
// - output n uses idle bits 2n+1:2n
// - third idle register only on twelve outputs
// - idle fields read/write, reset to 00
// - enabled output drives current steering mode
module clk_source_cfg #(
    parameter bit twelve_outputs = 1'b1                      // large variant present
) (
    input  wire logic                    clk,                  // system clock
    input  wire logic                    reset,                // sync reset, high
    input  wire clk_cfg_pkg::reg_req_t   req,                  // register request
    output var  logic [7:0]              rdata,                // read data
    input  wire logic [11:0]             outen,                // output enables
    input  wire logic                    first_diff_ref_true,  // pair one true
    input  wire logic                    first_diff_ref_comp,  // pair one comp
    input  wire logic                    second_diff_ref_true, // pair two true
    input  wire logic                    second_diff_ref_comp, // pair two comp
    input  wire logic                    crystal_in_pin,       // crystal input
    output var  logic                    crystal_out_pin,      // oscillator drive
    output var  logic                    osc_run,              // oscillator running
    output var  logic                    xtal_buf_en,          // crystal buffer on
    output var  logic [1:0]              ref_source,           // applied source
    output var  clk_cfg_pkg::leg_drive_t clock_output [12]     // differential outputs
);
    import clk_cfg_pkg::*;

    logic           policy_q, policy_d;                        // on-demand bit
    ref_src_t       ref_q, ref_d;                              // source field
    logic [23:0]    idle_q, idle_d;                            // packed idle codes
    logic [7:0]     rdata_q, rdata_d;                          // read register
    logic           osc_q, osc_d;                              // oscillator enable
    logic           buf_q, buf_d;                              // crystal buffer enable
    logic           odrv_q, odrv_d;                            // oscillator output
    logic           level_q, level_d;                          // selected reference

    // register writes
    always_comb
    begin
        policy_d = policy_q;
        ref_d    = ref_q;
        idle_d   = idle_q;
        if (req.wr)
        begin
            case (req.addr)
                OFS_OSC_POLICY: policy_d = req.wdata[POLICY_BIT];
                OFS_REF_SEL:    ref_d    = ref_src_t'(req.wdata[REF_SEL_MSB:REF_SEL_LSB]);
                OFS_IDLE0:      idle_d[7:0]   = req.wdata;
                OFS_IDLE1:      idle_d[15:8]  = req.wdata;
                OFS_IDLE2:
                begin
                    // third bank only on the large variant
                    if (twelve_outputs)
                        idle_d[23:16] = req.wdata;
                end
                default:        idle_d = idle_q;
            endcase
        end
    end

    // register reads, unmapped offsets return zero
    always_comb
    begin
        rdata_d = rdata_q;
        if (req.rd)
        begin
            case (req.addr)
                OFS_OSC_POLICY: rdata_d = {7'h00, policy_q};
                OFS_REF_SEL:    rdata_d = {6'h00, ref_q};
                OFS_IDLE0:      rdata_d = idle_q[7:0];
                OFS_IDLE1:      rdata_d = idle_q[15:8];
                OFS_IDLE2:      rdata_d = twelve_outputs ? idle_q[23:16] : 8'h00;
                default:        rdata_d = 8'h00;
            endcase
        end
    end

    // oscillator policy and reference routing
    always_comb
    begin
        osc_d = 1'b1;
        buf_d = 1'b1;
        case (ref_q)
            REF_DIFF0:  level_d = first_diff_ref_true & ~first_diff_ref_comp;
            REF_DIFF1:  level_d = second_diff_ref_true & ~second_diff_ref_comp;
            REF_XTAL:   level_d = crystal_in_pin;
            REF_BYPASS: level_d = crystal_in_pin;
            default:    level_d = 1'b0;
        endcase
        // on-demand runs only in crystal mode, else keep running except in bypass
        if (policy_q)
            osc_d = (ref_q == REF_XTAL);
        else
            osc_d = (ref_q != REF_BYPASS);
        // bypass turns the internal buffer off
        if (ref_q == REF_BYPASS)
        begin
            buf_d = 1'b0;
            osc_d = 1'b0;
        end
        odrv_d = osc_q & ~crystal_in_pin;
    end

    // register everything
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            policy_q <= RST_OSC_POLICY;
            ref_q    <= REF_DIFF0;
            idle_q   <= {RST_IDLE, RST_IDLE, RST_IDLE};
            rdata_q  <= 8'h00;
            osc_q    <= 1'b0;
            buf_q    <= 1'b1;
            odrv_q   <= 1'b0;
            level_q  <= 1'b0;
        end
        else
        begin
            policy_q <= policy_d;
            ref_q    <= ref_d;
            idle_q   <= idle_d;
            rdata_q  <= rdata_d;
            osc_q    <= osc_d;
            buf_q    <= buf_d;
            odrv_q   <= odrv_d;
            level_q  <= level_d;
        end
    end

    assign rdata           = rdata_q;
    assign osc_run         = osc_q;
    assign xtal_buf_en     = buf_q;
    assign crystal_out_pin = odrv_q;
    assign ref_source      = ref_q;

    // one driver per output, small variant keeps upper bank idle
    for (genvar n = 0; n < NUM_OUTPUTS; n++)
    begin : g_out
        output_driver u_drv (
            .clk       (clk),
            .reset     (reset),
            .ref_level (level_q),
            .enable    (outen[n] & (twelve_outputs | (n < 8))),
            .idle_code (idle_q[2*n +: 2]),
            .drive     (clock_output[n])
        );
    end

    // on-demand stops oscillator outside crystal mode
    property p_osc_on_demand;
        @(posedge clk) disable iff (reset)
        (policy_q && ref_q != REF_XTAL) |=> !osc_run;
    endproperty
    a_osc_on_demand: assert property (p_osc_on_demand) else $error("osc runs idle");

    // crystal mode always runs the oscillator
    property p_osc_xtal;
        @(posedge clk) disable iff (reset)
        (ref_q == REF_XTAL) [*2] |-> osc_run;
    endproperty
    a_osc_xtal: assert property (p_osc_xtal) else $error("osc off in crystal");

    // policy zero keeps oscillator on for differential inputs
    property p_osc_keep;
        @(posedge clk) disable iff (reset)
        (!policy_q && ref_q != REF_BYPASS) |=> osc_run;
    endproperty
    a_osc_keep: assert property (p_osc_keep) else $error("osc stopped");

    // first pair reaches the drivers
    property p_route_diff0;
        @(posedge clk) disable iff (reset)
        (ref_q == REF_DIFF0) |=>
            (level_q == ($past(first_diff_ref_true) & ~$past(first_diff_ref_comp)));
    endproperty
    a_route_diff0: assert property (p_route_diff0) else $error("pair one not routed");

    // bypass disables buffer and oscillator
    property p_bypass;
        @(posedge clk) disable iff (reset)
        (ref_q == REF_BYPASS) |=> (!xtal_buf_en && !osc_run);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass buffer on");

    // source read shows field and zero upper bits
    sequence s_ref_read;
        req.rd && !req.wr && (req.addr == OFS_REF_SEL);
    endsequence
    property p_ref_read;
        @(posedge clk) disable iff (reset)
        s_ref_read |=> (rdata[7:2] == 6'h00) && (rdata[1:0] == $past(ref_q));
    endproperty
    a_ref_read: assert property (p_ref_read) else $error("source read wrong");

    // idle write lands in the right slice
    property p_idle_write;
        @(posedge clk) disable iff (reset)
        (req.wr && req.addr == OFS_IDLE1) |=> (idle_q[15:8] == $past(req.wdata));
    endproperty
    a_idle_write: assert property (p_idle_write) else $error("idle write lost");

    // small variant has no third bank
    property p_variant;
        @(posedge clk) disable iff (reset)
        !twelve_outputs |-> (idle_q[23:16] == 8'h00);
    endproperty
    a_variant: assert property (p_variant) else $error("third bank written");

endmodule // clk_source_cfg

`default_nettype wire

// file: inc/clk_cfg_pkg.sv
/*
 * constants, types and helpers shared by the clock source and output idle
 * configuration slice of a clock fan-out buffer.
 * assumes a byte-wide register port fed by the serial bus front end.
 */
`default_nettype none

package clk_cfg_pkg;

    // register offsets
    localparam logic [7:0] OFS_OSC_POLICY = 8'h03;  // oscillator_run_policy
    localparam logic [7:0] OFS_REF_SEL    = 8'h04;  // reference_source_select
    localparam logic [7:0] OFS_IDLE0      = 8'h05;  // idle_state_outputs_0_to_3
    localparam logic [7:0] OFS_IDLE1      = 8'h06;  // idle_state_outputs_4_to_7
    localparam logic [7:0] OFS_IDLE2      = 8'h07;  // idle_state_outputs_8_to_11

    // field positions
    localparam int POLICY_BIT  = 0;                 // on-demand bit in its register
    localparam int REF_SEL_LSB = 0;                 // source field low bit
    localparam int REF_SEL_MSB = 1;                 // source field high bit

    // reset values
    localparam logic       RST_OSC_POLICY = 1'h1;   // on-demand after reset
    localparam logic [1:0] RST_REF_SEL    = 2'h0;   // first differential pair
    localparam logic [7:0] RST_IDLE       = 8'h00;  // both legs low

    // output counts
    localparam int NUM_OUTPUTS  = 12;               // outputs on the large variant
    localparam int OUTS_PER_REG = 4;                // idle codes per register
    localparam int IDLE_BITS    = 2 * NUM_OUTPUTS;  // packed idle code width

    // reference source codes
    typedef enum logic [1:0] {
        REF_DIFF0  = 2'b00,                         // first differential pair
        REF_DIFF1  = 2'b01,                         // second differential pair
        REF_XTAL   = 2'b10,                         // crystal or overdrive
        REF_BYPASS = 2'b11                          // single-ended bypass
    } ref_src_t;

    // idle codes of a disabled output
    localparam logic [1:0] IDLE_BOTH_LOW  = 2'h0;   // true low, comp low
    localparam logic [1:0] IDLE_DRIVE_LOW = 2'h1;   // true low, comp high

    // applied state of one output driver
    typedef enum logic {
        DRV_IDLE   = 1'b0,                          // idle code shown
        DRV_ACTIVE = 1'b1                           // low-power current steering
    } drv_state_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;                           // register offset
        logic       wr;                             // write strobe
        logic       rd;                             // read strobe
        logic [7:0] wdata;                          // write data
    } reg_req_t;

    // both legs of one differential output
    typedef struct packed {
        logic true_lvl;                             // true leg level
        logic comp_lvl;                             // complement leg level
        logic true_oe;                              // true leg driven
        logic comp_oe;                              // complement leg driven
    } leg_drive_t;

    // legs of a disabled output for an idle code
    function automatic leg_drive_t idle_drive(input logic [1:0] code);
        leg_drive_t d;
        d = '{1'b0, 1'b0, 1'b0, 1'b0};
        case (code)
            IDLE_BOTH_LOW:  d = '{1'b0, 1'b0, 1'b1, 1'b1};
            IDLE_DRIVE_LOW: d = '{1'b0, 1'b1, 1'b1, 1'b1};
            default:        d = '{1'b0, 1'b0, 1'b0, 1'b0};
        endcase
        return d;
    endfunction

endpackage

`default_nettype wire

// file: hdl/output_driver.sv
/*
 * one differential output driver: active steering or idle code, with
 * changes applied only during the low phase of the reference.
 * assumes ref_level is the registered selected reference level.
 */
`timescale 1ns/100ps
`default_nettype none

module output_driver (
    input  wire logic                    clk,        // system clock
    input  wire logic                    reset,      // sync reset, high
    input  wire logic                    ref_level,  // selected reference
    input  wire logic                    enable,     // output enable bit
    input  wire logic [1:0]              idle_code,  // disabled state code
    output var  clk_cfg_pkg::leg_drive_t drive       // both legs, registered
);
    import clk_cfg_pkg::*;

    drv_state_t state_q, state_d;                    // applied enable
    logic [1:0] code_q, code_d;                      // applied idle code
    leg_drive_t drive_q, drive_d;                    // leg register

    // next applied state and leg levels
    always_comb
    begin
        state_d = state_q;
        code_d  = code_q;
        // take new settings only while reference is low
        if (!ref_level)
        begin
            state_d = enable ? DRV_ACTIVE : DRV_IDLE;
            code_d  = idle_code;
        end
        case (state_q)
            DRV_ACTIVE: drive_d = '{ref_level, ~ref_level, 1'b1, 1'b1};
            DRV_IDLE:   drive_d = idle_drive(code_q);
            default:    drive_d = idle_drive(IDLE_BOTH_LOW);
        endcase
    end

    // register state
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= DRV_IDLE;
            code_q  <= IDLE_BOTH_LOW;
            drive_q <= '{1'b0, 1'b0, 1'b1, 1'b1};
        end
        else
        begin
            state_q <= state_d;
            code_q  <= code_d;
            drive_q <= drive_d;
        end
    end

    assign drive = drive_q;

    // idle outputs follow their code
    property p_idle_decode;
        @(posedge clk) disable iff (reset)
        (state_q == DRV_IDLE) |=> (drive_q == idle_drive($past(code_q)));
    endproperty
    a_idle_decode: assert property (p_idle_decode) else $error("idle legs wrong");

    // enabled outputs steer the reference
    property p_active;
        @(posedge clk) disable iff (reset)
        (state_q == DRV_ACTIVE) |=> (drive_q.true_lvl == $past(ref_level))
            && (drive_q.comp_lvl != drive_q.true_lvl) && drive_q.true_oe;
    endproperty
    a_active: assert property (p_active) else $error("active legs wrong");

    // state changes only after a low reference
    property p_apply_low;
        @(posedge clk) disable iff (reset)
        $changed(state_q) |-> !$past(ref_level);
    endproperty
    a_apply_low: assert property (p_apply_low) else $error("enable change at high");

endmodule // output_driver

`default_nettype wire

// file: bench/tb_top.sv
/*
 * self-checking bench for the clock source and output idle slice.
 * assumes the design package and design files are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

// one compare: counts it, reports a difference at once
`define CHK(got, exp, msg) \
    begin checked++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t %s", $time, msg); end end

module tb_top;
    import clk_cfg_pkg::*;

    logic          clk;                   // bench clock
    logic          reset;                 // sync reset, high
    reg_req_t      req;                   // register request
    logic [7:0]    rdata;                 // read data, large variant
    logic [7:0]    rdata_s;               // read data, small variant
    logic [11:0]   outen;                 // output enables
    logic          first_diff_ref_true;   // pair one true
    logic          first_diff_ref_comp;   // pair one comp
    logic          second_diff_ref_true;  // pair two true
    logic          second_diff_ref_comp;  // pair two comp
    logic          crystal_in_pin;        // crystal input
    logic          crystal_out_pin;       // oscillator drive
    logic          osc_run;               // oscillator running
    logic          xtal_buf_en;           // crystal buffer on
    logic [1:0]    ref_source;            // applied source
    leg_drive_t    outs [12];             // legs, large variant
    leg_drive_t    outs_s [12];           // legs, small variant
    logic [23:0]   idle_q;                // bench copy of idle codes
    logic [31:0]   lfsr_q;                // random state
    logic [7:0]    d;                     // scratch data
    logic [11:0]   en;                    // scratch enables
    logic [7:0]    ofs [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h02, 8'hFF};
    int            err_count;             // mismatches
    int            checked;               // compares made

    // twelve-output variant
    clk_source_cfg #(.twelve_outputs(1'b1)) uut (
        .clk(clk), .reset(reset), .req(req), .rdata(rdata), .outen(outen),
        .first_diff_ref_true(first_diff_ref_true), .first_diff_ref_comp(first_diff_ref_comp),
        .second_diff_ref_true(second_diff_ref_true),
        .second_diff_ref_comp(second_diff_ref_comp), .crystal_in_pin(crystal_in_pin),
        .crystal_out_pin(crystal_out_pin), .osc_run(osc_run), .xtal_buf_en(xtal_buf_en),
        .ref_source(ref_source), .clock_output(outs));

    // eight-output variant on the same stimulus
    clk_source_cfg #(.twelve_outputs(1'b0)) uut_small (
        .clk(clk), .reset(reset), .req(req), .rdata(rdata_s), .outen(outen),
        .first_diff_ref_true(first_diff_ref_true), .first_diff_ref_comp(first_diff_ref_comp),
        .second_diff_ref_true(second_diff_ref_true),
        .second_diff_ref_comp(second_diff_ref_comp), .crystal_in_pin(crystal_in_pin),
        .crystal_out_pin(), .osc_run(), .xtal_buf_en(), .ref_source(),
        .clock_output(outs_s));

    // free-running 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // shift register source of random values
    function automatic logic [31:0] next_rand();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction

    // expected legs of one output
    function automatic leg_drive_t exp_leg(input logic e, input logic lvl,
                                           input logic [1:0] code);
        if (e)
            return '{lvl, ~lvl, 1'b1, 1'b1};
        case (code)
            2'b00:   return '{1'b0, 1'b0, 1'b1, 1'b1};
            2'b01:   return '{1'b0, 1'b1, 1'b1, 1'b1};
            default: return '{1'b0, 1'b0, 1'b0, 1'b0};
        endcase
    endfunction

    // expected read-back of a register write
    function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] v);
        case (a)
            8'h03:                return v & 8'h01;
            8'h04:                return v & 8'h03;
            8'h05, 8'h06, 8'h07:  return v;
            default:              return 8'h00;
        endcase
    endfunction

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        req.addr  = a;
        req.wdata = v;
        req.wr    = 1'b1;
        @(negedge clk);
        req.wr    = 1'b0;
    endtask

    // one-cycle read strobe, data compared a cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        req.addr = a;
        req.rd   = 1'b1;
        @(negedge clk);
        req.rd   = 1'b0;
        `CHK(rdata, v, "read data")
    endtask

    // idle cycles
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // selected source gets v, all others the inverse
    task automatic set_pins(input int s, input logic v);
        first_diff_ref_true  = (s == 0) ? v : ~v;
        first_diff_ref_comp  = (s == 0) ? ~v : v;
        second_diff_ref_true = (s == 1) ? v : ~v;
        second_diff_ref_comp = (s == 1) ? ~v : v;
        crystal_in_pin       = (s >= 2) ? v : ~v;
    endtask

    // all legs of both variants
    task automatic check_outs(input logic [11:0] e, input logic lvl);
        for (int n = 0; n < 12; n++)
        begin
            `CHK(outs[n], exp_leg(e[n], lvl, idle_q[2*n +: 2]), "legs")
            if (n < 8)
                `CHK(outs_s[n], exp_leg(e[n], lvl, idle_q[2*n +: 2]), "small legs")
            else
                `CHK(outs_s[n], exp_leg(1'b0, lvl, 2'b00), "small high legs")
        end
    endtask

    // counts, then the verdict
    task automatic give_verdict();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // cuts a hang short
    initial
    begin
        #400000;
        err_count++;
        $display("MISMATCH t=%0t watchdog ran out", $time);
        give_verdict();
    end

    // main sequence
    initial
    begin
        reset = 1'b1;
        req = '0;
        outen = 12'h000;
        first_diff_ref_true = 1'b0;
        first_diff_ref_comp = 1'b0;
        second_diff_ref_true = 1'b0;
        second_diff_ref_comp = 1'b0;
        crystal_in_pin = 1'b0;
        lfsr_q = 32'h174c;
        idle_q = '0;
        err_count = 0;
        checked = 0;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        // reset values
        rd(OFS_OSC_POLICY, 8'h01);
        rd(OFS_REF_SEL, 8'h00);
        for (int r = 0; r < 3; r++)
            rd(OFS_IDLE0 + 8'(r), 8'h00);
        `CHK(rdata_s, 8'h00, "small third idle register")
        `CHK(xtal_buf_en, 1'b1, "buffer after reset")
        check_outs(12'h000, 1'b0);
        $display("test reset values done");
        // random writes, read-only bits and unmapped places
        for (int i = 0; i < 16; i++)
        begin
            d = 8'(next_rand());
            wr(ofs[i % 8], d);
            rd(ofs[i % 8], exp_rd(ofs[i % 8], d));
            if (ofs[i % 8] == OFS_IDLE2)
                `CHK(rdata_s, 8'h00, "small third idle register")
        end
        $display("test register access done");
        // oscillator policy against every source code
        for (int p = 0; p < 2; p++)
            for (int s = 0; s < 4; s++)
            begin
                wr(OFS_OSC_POLICY, 8'(p));
                wr(OFS_REF_SEL, 8'(s));
                wait_cyc(3);
                `CHK(ref_source, 2'(s), "applied source")
                `CHK(osc_run, logic'(s == 2 || (p == 0 && s != 3)), "oscillator")
                `CHK(xtal_buf_en, logic'(s != 3), "crystal buffer")
            end
        $display("test oscillator policy done");
        // idle codes of disabled outputs, every code first, then random
        wr(OFS_REF_SEL, 8'h00);
        set_pins(0, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            for (int r = 0; r < 3; r++)
            begin
                d = (i == 0) ? 8'hE4 : 8'(next_rand());
                wr(OFS_IDLE0 + 8'(r), d);
                idle_q[8*r +: 8] = d;
            end
            wait_cyc(4);
            check_outs(12'h000, 1'b0);
        end
        $display("test idle codes done");
        // enables applied only while the reference is low
        for (int r = 0; r < 3; r++)
            wr(OFS_IDLE0 + 8'(r), 8'h00);
        idle_q = '0;
        for (int i = 0; i < 4; i++)
        begin
            en = (i == 0) ? 12'hFFF : 12'(next_rand());
            set_pins(0, 1'b0);
            wait_cyc(2);
            outen = en;
            wait_cyc(4);
            check_outs(en, 1'b0);
            set_pins(0, 1'b1);
            wait_cyc(4);
            check_outs(en, 1'b1);
            outen = ~en;
            wait_cyc(6);
            check_outs(en, 1'b1);
            set_pins(0, 1'b0);
            wait_cyc(4);
            check_outs(~en, 1'b0);
        end
        $display("test glitch-free enable done");
        // reference routing for every source code
        outen = 12'hFFF;
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_REF_SEL, 8'(s));
            for (int v = 0; v < 2; v++)
            begin
                set_pins(s, 1'(v));
                wait_cyc(4);
                `CHK(outs[0], exp_leg(1'b1, 1'(v), 2'b00), "routed level")
                `CHK(crystal_out_pin, logic'(s == 2 && v == 0), "crystal drive")
            end
        end
        $display("test source routing done");
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
